// [common/serial_port_pkg.sv]
// Function
// - 8-bit mode: set rx done only if clear and multiproc off or stop one.
// - 8-bit accepted frame: stop bit to rx ninth bit, data to receive latch.
// - After each frame, wait for falling edge; rx done must be cleared first.
// - 9-bit frame: start 0, eight data LSB first, ninth bit, stop 1.
// - Buffer write copies tx ninth bit into shift register ninth position.
// - Transmit starts after next divide-by-16 rollover following the write.
// - 9-bit: start, nine bits, stop; tx done set as stop bit starts.
// - 9-bit fixed rate: clock over 64, or over 32 with baud doubler.
// - Receive only while enabled; starts on falling edge sampled every clock.
// - Start falling edge resets divide-by-16 counter at once.
// - Each bit is majority of samples at counter states 7, 8, 9.
// - Start bit not 0: abort, reset receiver, wait for new edge.
// - 9-bit accept: flag clear and multiproc off, or ninth one and address match.
// - 9-bit modes: received stop bit is not stored.
// - 9-bit variable mode: 9-bit framing with programmable baud timing.
// - Baud generator: 15-bit up counter started from high and low reload.
// - Variable rate: fsys over 16 times (32768 minus reload) plus fine.
// - Synchronous mode: shift rate fsys/12, or fsys/4 with multiproc set.
// - Given address compares only bits where the mask is one.
// - Broadcast address is address OR mask; zero bits don't care.
// - Reset clears slave address and mask, so any address is accepted.
// - Baud doubler sits at power control bit 7.
// - Baud generator runs only when enable bit 7 of high reload is set.
// - Fine adjust is a 4-bit field in bits 3 to 0.
package serial_port_pkg;
   localparam logic [1:0] MODE_SYNC = 2'h0;
   localparam logic [1:0] MODE_VAR8 = 2'h1;
   localparam logic [1:0] MODE_FIX9 = 2'h2;
   localparam logic [1:0] MODE_VAR9 = 2'h3;
   localparam int BAUD_DOUBLER_BIT = 7;
   localparam int BAUD_GEN_ENABLE_BIT = 7;
   localparam int FINE_MSB = 3;
   localparam logic [5:0] FIX_DIV64_LAST = 6'h3F;
   localparam logic [5:0] FIX_DIV32_LAST = 6'h1F;
   localparam logic [3:0] SYNC_DIV12_LAST = 4'hB;
   localparam logic [3:0] SYNC_DIV4_LAST = 4'h3;
   localparam logic [3:0] SAMPLE_A = 4'h7;
   localparam logic [3:0] SAMPLE_B = 4'h8;
   localparam logic [3:0] SAMPLE_C = 4'h9;
   localparam logic [3:0] LAST_PHASE = 4'hF;
   localparam logic [3:0] BITS_8 = 4'hA;
   localparam logic [3:0] BITS_9 = 4'hB;
   localparam logic [14:0] BAUD_RESET = 15'h0000;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam int FIFO_DEPTH = 8;
endpackage : serial_port_pkg

// [hw/rx_fifo.sv]
`timescale 1ns/1ps
// Small synchronous FIFO between receiver and buffer latch
module rx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   // Honest full and empty from the occupancy count
   assign inReady = (count_q != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign outValid = (count_q != '0);
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign outData = mem[rdPtr_q];

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wrPtr_q] <= inData;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
         if (pop)
            rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : rx_fifo

// [hw/nine_bit_async_serial_port.sv]
`timescale 1ns/1ps
module nine_bit_async_serial_port
   import serial_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] serialMode,
   input wire logic multiprocEnable,
   input wire logic rxEnable,
   input wire logic txNinthBit,
   input wire logic [7:0] powerControl,
   input wire logic [7:0] baudReloadHigh,
   input wire logic [7:0] baudReloadLow,
   input wire logic [7:0] baudFine,
   input wire logic slaveAddrWrite,
   input wire logic [7:0] slaveAddrIn,
   input wire logic [7:0] slaveMaskIn,
   input wire logic bufferWrite,
   input wire logic [7:0] bufferWriteData,
   input wire logic rxDoneClear,
   input wire logic txDoneClear,
   input wire logic rxIn,
   output logic txOut,
   output logic [7:0] serialBuffer,
   output logic rxNinthBit,
   output logic rxDoneFlag,
   output logic txDoneFlag,
   output logic syncShiftTick,
   output logic [7:0] slaveAddress,
   output logic [7:0] slaveAddressMask
);
   typedef enum logic [1:0] {RX_IDLE, RX_BITS} rx_state_t;

   logic [14:0] baudCnt_q;
   logic [3:0] fineCnt_q;
   logic [5:0] fixCnt_q;
   logic [3:0] syncCnt_q;
   logic tick16;
   logic [3:0] txPhase_q;
   logic txRoll;
   logic txPending_q;
   logic txBusy_q;
   logic [9:0] txShift_q;
   logic [3:0] txBitCnt_q;
   rx_state_t rxState_q;
   logic [3:0] rxPhase_q;
   logic [3:0] rxBitCnt_q;
   logic [2:0] votes_q;
   logic [9:0] rxShift_q;
   logic rxPrev_q;
   logic nineBit;
   logic [3:0] frameBits;
   logic fifoInValid;
   logic fifoInReady;
   logic [8:0] fifoInData;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [8:0] fifoOutData;
   logic voted;
   logic bitEnd;

   // Two-of-three majority
   function automatic logic majority(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : majority

   // Given or broadcast address match; zero bits of the mask (given) or of address OR mask (broadcast) are don't care
   function automatic logic addrMatch(input logic [7:0] b, input logic [7:0] a, input logic [7:0] m);
      logic given;
      logic bcast;
      given = ((b ^ a) & m) == 8'h00;
      bcast = ((b ^ 8'hFF) & (a | m)) == 8'h00;
      return given | bcast;
   endfunction : addrMatch

   assign nineBit = serialMode[1];
   assign frameBits = nineBit ? BITS_9 : BITS_8;

   // Baud generator with fine adjust stretching each 16-tick period
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         baudCnt_q <= BAUD_RESET;
         fineCnt_q <= 4'h0;
         fixCnt_q <= 6'h00;
      end
      else
      begin
         fixCnt_q <= (fixCnt_q == (powerControl[BAUD_DOUBLER_BIT] ? FIX_DIV32_LAST : FIX_DIV64_LAST))
            ? 6'h00 : fixCnt_q + 6'h01;
         if (!baudReloadHigh[BAUD_GEN_ENABLE_BIT])
         begin
            baudCnt_q <= {baudReloadHigh[6:0], baudReloadLow};
            fineCnt_q <= 4'h0;
         end
         else if (fineCnt_q != 4'h0)
            fineCnt_q <= fineCnt_q - 4'h1;
         else if (baudCnt_q == 15'h7FFF)
         begin
            baudCnt_q <= {baudReloadHigh[6:0], baudReloadLow};
            fineCnt_q <= (txPhase_q == LAST_PHASE) ? baudFine[FINE_MSB:0] : 4'h0;
         end
         else
            baudCnt_q <= baudCnt_q + 15'h0001;
      end
   end

   // Sixteenth-bit tick: fixed divider for mode 2, generator for modes 1 and 3
   // Mode 2 ticks every 2 or 4 clocks, so sixteen ticks span fsys/32 or fsys/64
   assign tick16 = (serialMode == MODE_FIX9) ? (fixCnt_q[0] &&
      (powerControl[BAUD_DOUBLER_BIT] || fixCnt_q[1]))
      : (baudReloadHigh[BAUD_GEN_ENABLE_BIT] && fineCnt_q == 4'h0 && baudCnt_q == 15'h7FFF);

   // Synchronous-mode shift tick only; the rest of mode 0 is out of scope
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         syncCnt_q <= 4'h0;
         syncShiftTick <= 1'b0;
      end
      else
      begin
         syncCnt_q <= (syncCnt_q >= (multiprocEnable ? SYNC_DIV4_LAST : SYNC_DIV12_LAST)) ? 4'h0 : syncCnt_q + 4'h1;
         syncShiftTick <= (serialMode == MODE_SYNC) &&
            (syncCnt_q == (multiprocEnable ? SYNC_DIV4_LAST : SYNC_DIV12_LAST));
      end
   end

   // Transmit divide-by-16 counter, free running on ticks
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         txPhase_q <= 4'h0;
      else if (tick16)
         txPhase_q <= txPhase_q + 4'h1;
   end
   assign txRoll = tick16 && (txPhase_q == LAST_PHASE);

   // Transmitter: a write loads data and ninth bit, then waits for a rollover
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         txShift_q <= 10'h3FF;
         txPending_q <= 1'b0;
         txBusy_q <= 1'b0;
         txBitCnt_q <= 4'h0;
         txOut <= 1'b1;
      end
      else if (bufferWrite && !txBusy_q && !txPending_q)
      begin
         txShift_q <= nineBit ? {1'b1, txNinthBit, bufferWriteData}
            : {2'b11, bufferWriteData};
         txPending_q <= 1'b1;
      end
      else if (txRoll && txPending_q)
      begin
         txPending_q <= 1'b0;
         txBusy_q <= 1'b1;
         txOut <= 1'b0;
         txBitCnt_q <= 4'h1;
      end
      else if (txRoll && txBusy_q)
      begin
         txOut <= txShift_q[0];
         txShift_q <= {1'b1, txShift_q[9:1]};
         txBitCnt_q <= txBitCnt_q + 4'h1;
         if (txBitCnt_q == frameBits)
         begin
            txBusy_q <= 1'b0;
            txOut <= 1'b1;
         end
      end
   end

   // Transmit done raised as the stop bit starts; set wins over clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         txDoneFlag <= 1'b0;
      else if (txRoll && txBusy_q && txBitCnt_q == frameBits - 4'h1)
         txDoneFlag <= 1'b1;
      else if (txDoneClear)
         txDoneFlag <= 1'b0;
   end

   assign voted = majority(votes_q);
   assign bitEnd = tick16 && rxPhase_q == LAST_PHASE;

   // Receiver: edge detect, 16x phase, vote, start check, shift
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rxState_q <= RX_IDLE;
         rxPhase_q <= 4'h0;
         rxBitCnt_q <= 4'h0;
         votes_q <= 3'h0;
         rxShift_q <= 10'h000;
         rxPrev_q <= 1'b1;
      end
      else
      begin
         rxPrev_q <= rxIn;
         unique case (rxState_q)
            RX_IDLE:
            begin
               if (rxEnable && !rxDoneFlag && rxPrev_q && !rxIn && serialMode != MODE_SYNC)
               begin
                  rxState_q <= RX_BITS;
                  rxPhase_q <= 4'h0;
                  rxBitCnt_q <= 4'h0;
               end
            end
            RX_BITS:
            begin
               if (tick16)
               begin
                  rxPhase_q <= rxPhase_q + 4'h1;
                  if (rxPhase_q == SAMPLE_A)
                     votes_q[0] <= rxIn;
                  if (rxPhase_q == SAMPLE_B)
                     votes_q[1] <= rxIn;
                  if (rxPhase_q == SAMPLE_C)
                     votes_q[2] <= rxIn;
               end
               if (!rxEnable)
                  rxState_q <= RX_IDLE;
               else if (bitEnd)
               begin
                  rxBitCnt_q <= rxBitCnt_q + 4'h1;
                  if (rxBitCnt_q == 4'h0 && voted)
                     rxState_q <= RX_IDLE;
                  else if (rxBitCnt_q != 4'h0)
                     rxShift_q <= {voted, rxShift_q[9:1]};
                  if (rxBitCnt_q == frameBits - 4'h1)
                     rxState_q <= RX_IDLE;
               end
            end
            default:
               rxState_q <= RX_IDLE;
         endcase
      end
   end

   // Acceptance of a completed frame into the FIFO
   always_comb
   begin
      fifoInValid = 1'b0;
      fifoInData = 9'h000;
      if (rxState_q == RX_BITS && rxEnable && bitEnd && rxBitCnt_q == frameBits - 4'h1)
      begin
         if (nineBit)
         begin
            // Shift holds eight data bits then ninth; the stop bit is dropped
            fifoInData = {rxShift_q[9], rxShift_q[8:1]};
            fifoInValid = !multiprocEnable ||
               (rxShift_q[9] && addrMatch(rxShift_q[8:1], slaveAddress, slaveAddressMask));
         end
         else
         begin
            fifoInData = {voted, rxShift_q[9:2]};
            fifoInValid = !multiprocEnable || voted;
         end
      end
   end

   rx_fifo #(
      .WIDTH(9),
      .DEPTH(FIFO_DEPTH)
   ) rxFifo (
      .clk(clk),
      .rst(rst),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(fifoInData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   // Latch drains only while done flag is clear, one frame per flag
   assign fifoOutReady = !rxDoneFlag;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         serialBuffer <= 8'h00;
         rxNinthBit <= 1'b0;
         rxDoneFlag <= 1'b0;
      end
      else if (fifoOutValid && fifoOutReady)
      begin
         serialBuffer <= fifoOutData[7:0];
         rxNinthBit <= fifoOutData[8];
         rxDoneFlag <= 1'b1;
      end
      else if (rxDoneClear)
         rxDoneFlag <= 1'b0;
   end

   // Address and mask registers, cleared by reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         slaveAddress <= ADDR_RESET;
         slaveAddressMask <= ADDR_RESET;
      end
      else if (slaveAddrWrite)
      begin
         slaveAddress <= slaveAddrIn;
         slaveAddressMask <= slaveMaskIn;
      end
   end

   property p_tx_start_after_roll;
      @(posedge clk) disable iff (rst) (txRoll && txPending_q) |=> (txOut == 1'b0 && txBusy_q);
   endproperty
   a_tx_start_after_roll: assert property (p_tx_start_after_roll) else $error("tx start misaligned");

   property p_rx_abort;
      @(posedge clk) disable iff (rst) (rxState_q == RX_BITS && rxEnable && bitEnd && rxBitCnt_q == 4'h0 && voted)
         |=> rxState_q == RX_IDLE;
   endproperty
   a_rx_abort: assert property (p_rx_abort) else $error("bad start not aborted");

   property p_addr_reset;
      @(posedge clk) disable iff (rst) $fell(rst) |-> slaveAddress == 8'h00;
   endproperty
   a_addr_reset: assert property (p_addr_reset) else $error("address not cleared");

   property p_tx_idle_high;
      @(posedge clk) disable iff (rst) (!txBusy_q) |-> txOut;
   endproperty
   a_tx_idle_high: assert property (p_tx_idle_high) else $error("idle line low");

   property p_rx_done_sticky;
      @(posedge clk) disable iff (rst) (rxDoneFlag && !rxDoneClear) |=> rxDoneFlag;
   endproperty
   a_rx_done_sticky: assert property (p_rx_done_sticky) else $error("rx done lost");

   property p_edge_resets_phase;
      @(posedge clk) disable iff (rst) (rxState_q == RX_IDLE ##1 rxState_q == RX_BITS) |-> rxPhase_q == 4'h0;
   endproperty
   a_edge_resets_phase: assert property (p_edge_resets_phase) else $error("phase not reset");

   property p_mp8_stop;
      @(posedge clk) disable iff (rst) (fifoInValid && !nineBit && multiprocEnable) |-> fifoInData[8];
   endproperty
   a_mp8_stop: assert property (p_mp8_stop) else $error("bad stop accepted");

   property p_mp9_addr;
      @(posedge clk) disable iff (rst) (fifoInValid && nineBit && multiprocEnable) |-> fifoInData[8];
   endproperty
   a_mp9_addr: assert property (p_mp9_addr) else $error("data byte accepted");

   property p_tx_done_at_stop;
      @(posedge clk) disable iff (rst) $rose(txDoneFlag) |-> (txOut && txBusy_q);
   endproperty
   a_tx_done_at_stop: assert property (p_tx_done_at_stop) else $error("tx done off the stop bit");

   property p_rx_latch;
      @(posedge clk) disable iff (rst) (fifoOutValid && fifoOutReady)
         |=> (rxDoneFlag && {rxNinthBit, serialBuffer} == $past(fifoOutData));
   endproperty
   a_rx_latch: assert property (p_rx_latch) else $error("latch or flag not loaded");

   c_addr_accept: cover property (@(posedge clk) fifoInValid && nineBit && multiprocEnable);
   c_frame_reject: cover property (@(posedge clk) rxState_q == RX_BITS && bitEnd
      && rxBitCnt_q == frameBits - 4'h1 && !fifoInValid);
   c_tx_done: cover property (@(posedge clk) $rose(txDoneFlag));
   c_rx_done: cover property (@(posedge clk) $rose(rxDoneFlag));
   c_abort: cover property (@(posedge clk) rxState_q == RX_BITS ##1 rxState_q == RX_IDLE && !fifoInValid);
endmodule : nine_bit_async_serial_port

// [verif/serial_node_model.sv]
`timescale 1ns/1ps
// Remote node: drives our receive line, samples our transmit line
module serial_node_model (
   input wire logic clk,
   output logic nodeTx,
   input wire logic nodeRx,
   input wire logic doneSense
);
   int bitClocks = 32;
   // Line idles high between frames
   initial nodeTx = 1'b1;
   // One-clock glitch mid-bit upsets at most one of the three votes
   task automatic sendBit(input logic b, input logic glitch);
      for (int i = 0; i < bitClocks; i++)
      begin
         @(negedge clk);
         nodeTx = (glitch && i == bitClocks / 2) ? ~b : b;
      end
   endtask : sendBit
   // Start 0, data LSB first, ninth bit marks addresses, stop
   task automatic sendFrame(input logic [8:0] d, input int nb, input logic stopB, input logic glitch);
      sendBit(1'b0, 1'b0);
      for (int i = 0; i < nb; i++)
         sendBit(d[i], glitch);
      sendBit(stopB, 1'b0);
      sendBit(1'b1, 1'b0);
   endtask : sendFrame
   // Low pulse far shorter than the start-bit vote window
   task automatic sendRunt();
      @(negedge clk);
      nodeTx = 1'b0;
      repeat (3) @(negedge clk);
      nodeTx = 1'b1;
      repeat (12 * bitClocks) @(negedge clk);
   endtask : sendRunt
   // Mid-cell sampling on falling edges, clear of the edge that moves the line
   task automatic capture(input int nb, output logic [9:0] bits, output int waitClks,
                          output logic doneMid, output logic doneStop);
      bits = 10'h3FF;
      waitClks = 0;
      doneMid = 1'b1;
      doneStop = 1'b0;
      while (nodeRx !== 1'b0 && waitClks < 4000)
      begin
         @(negedge clk);
         waitClks++;
      end
      repeat (bitClocks / 2) @(negedge clk);
      for (int i = 0; i <= nb; i++)
      begin
         repeat (bitClocks) @(negedge clk);
         bits[i] = nodeRx;
         if (i == nb - 1)
            doneMid = doneSense;
         doneStop = doneSense;
      end
   endtask : capture
endmodule : serial_node_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top import serial_port_pkg::*;;
   logic clk, rst, multiprocEnable, rxEnable, txNinthBit, slaveAddrWrite, bufferWrite;
   logic rxDoneClear, txDoneClear, rxIn, txOut, rxNinthBit, rxDoneFlag, txDoneFlag, syncShiftTick;
   logic [1:0] serialMode;
   logic [7:0] powerControl, baudReloadHigh, baudReloadLow, baudFine, slaveAddrIn, slaveMaskIn;
   logic [7:0] bufferWriteData, serialBuffer, slaveAddress, slaveAddressMask;
   int errTotal, numChecks, cycles;
   // {accepted, ninth bit, byte} against address A4 with mask FA
   logic [9:0] addrCases [5] = '{10'h0A0, 10'h3A0, 10'h1A2, 10'h3A5, 10'h3FE};

   nine_bit_async_serial_port DUT (.clk, .rst, .serialMode, .multiprocEnable, .rxEnable, .txNinthBit,
      .powerControl, .baudReloadHigh, .baudReloadLow, .baudFine, .slaveAddrWrite, .slaveAddrIn,
      .slaveMaskIn, .bufferWrite, .bufferWriteData, .rxDoneClear, .txDoneClear, .rxIn, .txOut,
      .serialBuffer, .rxNinthBit, .rxDoneFlag, .txDoneFlag, .syncShiftTick, .slaveAddress,
      .slaveAddressMask);
   serial_node_model node (.clk, .nodeTx(rxIn), .nodeRx(txOut), .doneSense(txDoneFlag));

   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Hang guard, well above the expected run length
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         errTotal++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      numChecks++;
      if (got !== exp)
      begin
         errTotal++;
         $display("BAD at %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic setup(input logic [1:0] m, input logic baud_doubler, input logic mp, input int bc);
      @(negedge clk);
      serialMode = m;
      powerControl = {baud_doubler, 7'h00};
      // Generator only in variable modes, so it restarts from the reload value
      baudReloadHigh = {m[0], 7'h7F};
      multiprocEnable = mp;
      node.bitClocks = bc;
   endtask : setup

   task automatic writeBuf(input logic [7:0] d, input logic n);
      @(negedge clk);
      bufferWrite = 1'b1;
      bufferWriteData = d;
      txNinthBit = n;
      @(negedge clk);
      bufferWrite = 1'b0;
   endtask : writeBuf

   task automatic clearFlags();
      @(negedge clk);
      rxDoneClear = 1'b1;
      txDoneClear = 1'b1;
      @(negedge clk);
      rxDoneClear = 1'b0;
      txDoneClear = 1'b0;
   endtask : clearFlags

   // Frame out, captured by the node; waits out the stop bit before the next write
   task automatic txCase(input logic [7:0] d, input logic n, input int nb);
      logic [9:0] bits;
      int waitClks;
      logic doneMid, doneStop;
      fork
         node.capture(nb, bits, waitClks, doneMid, doneStop);
         writeBuf(d, n);
      join
      check(16'(bits), 16'((nb == 9) ? {1'b1, n, d} : {2'b11, d}));
      check(16'(waitClks <= node.bitClocks + 4), 16'h0001);
      check(16'({doneMid, doneStop}), 16'h0001);
      clearFlags();
      repeat (node.bitClocks) @(negedge clk);
   endtask : txCase

   task automatic rxCase(input logic [8:0] d, input int nb, input logic stopB, input logic acc, input logic nin);
      node.sendFrame(d, nb, stopB, 1'b1);
      check(16'(rxDoneFlag), 16'(acc));
      if (acc)
         check({7'h00, rxNinthBit, serialBuffer}, {7'h00, nin, d[7:0]});
      clearFlags();
   endtask : rxCase

   // Gap between shift ticks in synchronous mode
   task automatic syncGap(input logic mp, input int exp);
      int n;
      n = 0;
      multiprocEnable = mp;
      writeBuf(8'h5A, 1'b0);
      while (syncShiftTick !== 1'b1 && n < 60)
      begin
         @(negedge clk);
         n++;
      end
      n = 0;
      @(negedge clk);
      while (syncShiftTick !== 1'b1 && n < 60)
      begin
         @(negedge clk);
         n++;
      end
      check(16'(n + 1), 16'(exp));
      repeat (150) @(negedge clk);
      clearFlags();
   endtask : syncGap

   // Main sequence
   initial
   begin
      rst = 1'b1;
      {multiprocEnable, rxEnable, txNinthBit, slaveAddrWrite, bufferWrite, rxDoneClear, txDoneClear} = 7'h00;
      serialMode = MODE_FIX9;
      powerControl = 8'h80;
      baudReloadHigh = 8'h7F;
      baudReloadLow = 8'hFE;
      baudFine = 8'h03;
      {slaveAddrIn, slaveMaskIn, bufferWriteData} = 24'h00_0000;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      check({11'h000, txOut, rxDoneFlag, txDoneFlag, rxNinthBit, 1'b0}, 16'h0010);
      check({slaveAddress, slaveAddressMask}, 16'h0000);
      $display("test reset done");
      setup(MODE_FIX9, 1'b1, 1'b0, 32);
      txCase(8'hA5, 1'b1, 9);
      txCase(8'h5A, 1'b0, 9);
      setup(MODE_FIX9, 1'b0, 1'b0, 64);
      txCase(8'hC3, 1'b1, 9);
      $display("test transmit done");
      setup(MODE_FIX9, 1'b1, 1'b0, 32);
      rxEnable = 1'b1;
      rxCase(9'h03C, 9, 1'b1, 1'b1, 1'b0);
      rxCase(9'h1C3, 9, 1'b1, 1'b1, 1'b1);
      node.sendRunt();
      check(16'(rxDoneFlag), 16'h0000);
      node.sendFrame(9'h011, 9, 1'b1, 1'b0);
      node.sendFrame(9'h022, 9, 1'b1, 1'b0);
      check(16'(serialBuffer), 16'h0011);
      clearFlags();
      repeat (4) @(negedge clk);
      check(16'(rxDoneFlag), 16'h0000);
      rxEnable = 1'b0;
      rxCase(9'h055, 9, 1'b1, 1'b0, 1'b0);
      rxEnable = 1'b1;
      $display("test receive done");
      multiprocEnable = 1'b1;
      rxCase(9'h137, 9, 1'b1, 1'b1, 1'b1);
      slaveAddrIn = 8'hA4;
      slaveMaskIn = 8'hFA;
      slaveAddrWrite = 1'b1;
      @(negedge clk);
      slaveAddrWrite = 1'b0;
      check({slaveAddress, slaveAddressMask}, 16'hA4FA);
      foreach (addrCases[i])
         rxCase(addrCases[i][8:0], 9, 1'b1, addrCases[i][9], 1'b1);
      $display("test address done");
      setup(MODE_VAR8, 1'b0, 1'b1, 35);
      rxCase(9'h069, 8, 1'b0, 1'b0, 1'b0);
      setup(MODE_VAR8, 1'b0, 1'b0, 35);
      rxCase(9'h069, 8, 1'b0, 1'b1, 1'b0);
      rxCase(9'h096, 8, 1'b1, 1'b1, 1'b1);
      txCase(8'h81, 1'b0, 8);
      setup(MODE_VAR9, 1'b0, 1'b0, 35);
      txCase(8'h3E, 1'b1, 9);
      rxCase(9'h1E7, 9, 1'b1, 1'b1, 1'b1);
      $display("test variable rate done");
      baudReloadHigh = 8'h7F;
      writeBuf(8'h99, 1'b0);
      repeat (300) @(negedge clk);
      check(16'({txOut, txDoneFlag}), 16'h0002);
      baudReloadHigh = 8'hFF;
      repeat (500) @(negedge clk);
      check(16'(txDoneFlag), 16'h0001);
      clearFlags();
      $display("test generator enable done");
      setup(MODE_SYNC, 1'b0, 1'b0, 32);
      syncGap(1'b0, 12);
      syncGap(1'b1, 4);
      $display("test sync rate done");
      summarize();
   end
endmodule : tb_top
